// File: core/ebio_pin_sample.sv
// Sampling of one port's pin levels for the pin register read path.
// Assumes pins are synchronous to clock_in.
module ebio_pin_sample (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] dig_in,
	output logic [7:0] pins_out
);

	logic [7:0] pins_d;

	// Pins given to the analog side read as zero
	assign pins_d = pin_in & dig_in;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pins_out <= 8'h00;
		end else if (clk_en_in) begin
			pins_out <= pins_d;
		end
	end

endmodule

// File: core/ebio_port.sv
// Pin driver of one byte-wide port: direction, output value, enable.
// Assumes the caller has resolved bus and peripheral ownership per pin.
module ebio_port (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] dir_in,
	input wire logic [7:0] lat_in,
	input wire logic [7:0] drv_en_in,
	input wire logic [7:0] drv_val_in,
	input wire logic [7:0] hiz_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_out
);

	logic [7:0] oe_d;
	logic [7:0] val_d;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// Forced drive beats forced input, which beats the direction bit
			assign oe_d[i] = drv_en_in[i] | (~hiz_in[i] & ~dir_in[i]);
			assign val_d[i] = drv_en_in[i] ? drv_val_in[i] : lat_in[i];
		end
	endgenerate

	// Reset leaves every driver off so all pins start as inputs
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_oe_out <= 8'h00;
			pin_out <= 8'h00;
		end else if (clk_en_in) begin
			pin_oe_out <= oe_d;
			pin_out <= val_d;
		end
	end

endmodule

// File: core/ebio_top.sv
// Two byte-wide I/O ports sharing pins with the external memory bus,
// reached over AXI4-Lite. Assumes pins and bus strobes are synchronous
// to clock_in and that the bus master keeps one write and one read open.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module ebio_top (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [3:0] mem_addr_hi_in,
	input wire logic mem_addr_latch_in,
	input wire logic mem_out_enable_in,
	input wire logic write_low_strobe_in,
	input wire logic write_high_strobe_in,
	input wire logic byte_address_bit_in,
	input wire logic lower_byte_select_in,
	input wire logic upper_byte_select_in,
	input wire logic [3:0] pwm_h_en_in,
	input wire logic [3:0] pwm_h_val_in,
	input wire logic [7:0] ph_ovr_out_en_in,
	input wire logic [7:0] ph_ovr_out_val_in,
	input wire logic [7:0] ph_ovr_in_en_in,
	input wire logic [7:0] pj_ovr_out_en_in,
	input wire logic [7:0] pj_ovr_out_val_in,
	input wire logic [7:0] pj_ovr_in_en_in,
	input wire logic psp_mode_in,
	input wire logic [7:0] ph_pin_in,
	output logic [7:0] ph_pin_out,
	output logic [7:0] ph_pin_oe_out,
	input wire logic [7:0] pj_pin_in,
	output logic [7:0] pj_pin_out,
	output logic [7:0] pj_pin_oe_out,
	output logic ph_lo_ttl_out,
	output logic [3:0] analog_sel_out,
	output logic ext_bus_en_out,
	output logic [1:0] bus_write_style_out,
	output logic [1:0] bus_wait_out,
	output logic pwm_pin_remap_out
);

`include "ebio_map.svh"

	ebio_pkg::ebio_wst_t ws_q;
	ebio_pkg::ebio_wst_t ws_d;
	ebio_pkg::ebio_rst_t rs_q;
	ebio_pkg::ebio_rst_t rs_d;

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb_q;

	logic [7:0] ph_dir_q;
	logic [7:0] ph_lat_q;
	logic [7:0] pj_dir_q;
	logic [7:0] pj_lat_q;
	logic [7:0] ebc_q;
	logic [3:0] ana_q;
	logic remap_q;
	logic ttl_q;
	logic [7:0] ph_pins;
	logic [7:0] pj_pins;

	// Write channel handshakes and the merged write request
	wire aw_take = s_axi_awvalid_in & awready_q;
	wire w_take = s_axi_wvalid_in & wready_q;
	wire wr_fire = (ws_d == ebio_pkg::ws_resp) && (ws_q != ebio_pkg::ws_resp);
	wire [7:0] wr_addr = (ws_q == ebio_pkg::ws_got_a) ? aw_addr_q : s_axi_awaddr_in;
	wire [7:0] wr_data = (ws_q == ebio_pkg::ws_got_w) ? w_data_q : s_axi_wdata_in[7:0];
	wire wr_strb = (ws_q == ebio_pkg::ws_got_w) ? w_strb_q : s_axi_wstrb_in[0];
	wire [7:0] wr_word = wr_addr & `EBIO_ADDR_WORD;
	// Registers are one byte wide, so only lane 0 carries data
	wire wr_be = wr_fire & wr_strb;

	wire wr_ph_pins = wr_word == `EBIO_OFS_PH_PINS;
	wire wr_ph_lat = wr_word == `EBIO_OFS_PH_LAT;
	wire wr_ph_dir = wr_word == `EBIO_OFS_PH_DIR;
	wire wr_pj_pins = wr_word == `EBIO_OFS_PJ_PINS;
	wire wr_pj_lat = wr_word == `EBIO_OFS_PJ_LAT;
	wire wr_pj_dir = wr_word == `EBIO_OFS_PJ_DIR;
	wire wr_ebc = wr_word == `EBIO_OFS_EBC;
	wire wr_ana = wr_word == `EBIO_OFS_ANA;
	wire wr_opt = wr_word == `EBIO_OFS_OPT;
	wire wr_hit = wr_ph_pins | wr_ph_lat | wr_ph_dir | wr_pj_pins | wr_pj_lat |
		wr_pj_dir | wr_ebc | wr_ana | wr_opt;

	// A pin register write lands in the latch, never on the pins directly
	wire ld_ph_lat = wr_be & (wr_ph_lat | wr_ph_pins);
	wire ld_pj_lat = wr_be & (wr_pj_lat | wr_pj_pins);
	wire ld_ph_dir = wr_be & wr_ph_dir;
	wire ld_pj_dir = wr_be & wr_pj_dir;
	wire ld_ebc = wr_be & wr_ebc;
	wire ld_ana = wr_be & wr_ana;
	wire ld_opt = wr_be & wr_opt;

	// Read decode
	wire ar_take = s_axi_arvalid_in & arready_q;
	wire [7:0] rd_word = s_axi_araddr_in & `EBIO_ADDR_WORD;
	wire [7:0] rd_byte =
		(rd_word == `EBIO_OFS_PH_PINS) ? ph_pins :
		(rd_word == `EBIO_OFS_PH_LAT) ? ph_lat_q :
		(rd_word == `EBIO_OFS_PH_DIR) ? ph_dir_q :
		(rd_word == `EBIO_OFS_PJ_PINS) ? pj_pins :
		(rd_word == `EBIO_OFS_PJ_LAT) ? pj_lat_q :
		(rd_word == `EBIO_OFS_PJ_DIR) ? pj_dir_q :
		(rd_word == `EBIO_OFS_EBC) ? ebc_q :
		(rd_word == `EBIO_OFS_ANA) ? {4'h0, ana_q} :
		(rd_word == `EBIO_OFS_OPT) ? {7'h00, remap_q} : 8'h00;
	wire rd_hit = (rd_word == `EBIO_OFS_PH_PINS) | (rd_word == `EBIO_OFS_PH_LAT) |
		(rd_word == `EBIO_OFS_PH_DIR) | (rd_word == `EBIO_OFS_PJ_PINS) |
		(rd_word == `EBIO_OFS_PJ_LAT) | (rd_word == `EBIO_OFS_PJ_DIR) |
		(rd_word == `EBIO_OFS_EBC) | (rd_word == `EBIO_OFS_ANA) |
		(rd_word == `EBIO_OFS_OPT);

	// Pin ownership
	wire bus_en = ~ebc_q[`EBIO_EBC_DIS];
	wire [7:0] pj_bus_vec = bus_en ? `EBIO_PJ_BUS_PINS : 8'h00;
	wire [7:0] pj_bus_val = {upper_byte_select_in, lower_byte_select_in, 1'b0,
		byte_address_bit_in, write_high_strobe_in, write_low_strobe_in,
		mem_out_enable_in, mem_addr_latch_in};
	// Overrides apply only to pins the bus does not own
	wire [7:0] pj_drv_en = pj_bus_vec | pj_ovr_out_en_in;
	wire [7:0] pj_drv_val = (pj_bus_vec & pj_bus_val) | (~pj_bus_vec & pj_ovr_out_val_in);
	wire [7:0] pj_hiz = ~pj_bus_vec & pj_ovr_in_en_in;

	wire [7:0] ph_bus_vec = bus_en ? `EBIO_PH_BUS_PINS : 8'h00;
	wire [3:0] pwm_en = remap_q ? 4'h0 : pwm_h_en_in;
	wire [7:0] ph_fn_vec = ph_bus_vec | {pwm_en, 4'h0};
	wire [7:0] ph_fn_val = {pwm_h_val_in, mem_addr_hi_in};
	wire [7:0] ph_ana_vec = {ana_q, 4'h0};
	// An analog pin keeps its driver off unless the bus or a PWM owns it
	wire [7:0] ph_drv_en = ph_fn_vec | (ph_ovr_out_en_in & ~ph_ana_vec);
	wire [7:0] ph_drv_val = (ph_fn_vec & ph_fn_val) | (~ph_fn_vec & ph_ovr_out_val_in);
	wire [7:0] ph_hiz = ~ph_fn_vec & (ph_ovr_in_en_in | ph_ana_vec);
	wire ttl_d = bus_en | psp_mode_in;

	// Write channel state
	always_comb begin
		ws_d = ws_q;
		unique case (ws_q)
			ebio_pkg::ws_idle: begin
				if (aw_take && w_take) begin
					ws_d = ebio_pkg::ws_resp;
				end else if (aw_take) begin
					ws_d = ebio_pkg::ws_got_a;
				end else if (w_take) begin
					ws_d = ebio_pkg::ws_got_w;
				end
			end
			ebio_pkg::ws_got_a: begin
				if (w_take) begin
					ws_d = ebio_pkg::ws_resp;
				end
			end
			ebio_pkg::ws_got_w: begin
				if (aw_take) begin
					ws_d = ebio_pkg::ws_resp;
				end
			end
			ebio_pkg::ws_resp: begin
				if (s_axi_bready_in) begin
					ws_d = ebio_pkg::ws_idle;
				end
			end
		endcase
	end

	// Read channel state
	always_comb begin
		rs_d = rs_q;
		unique case (rs_q)
			ebio_pkg::rs_idle: begin
				if (ar_take) begin
					rs_d = ebio_pkg::rs_data;
				end
			end
			ebio_pkg::rs_data: begin
				if (s_axi_rready_in) begin
					rs_d = ebio_pkg::rs_idle;
				end
			end
		endcase
	end

	// Ready flags come from flops; they drop once each channel is taken
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ws_q <= ebio_pkg::ws_idle;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `EBIO_RESP_OKAY;
		end else if (clk_en_in) begin
			ws_q <= ws_d;
			awready_q <= (ws_d == ebio_pkg::ws_idle) || (ws_d == ebio_pkg::ws_got_w);
			wready_q <= (ws_d == ebio_pkg::ws_idle) || (ws_d == ebio_pkg::ws_got_a);
			bvalid_q <= ws_d == ebio_pkg::ws_resp;
			if (wr_fire) begin
				bresp_q <= wr_hit ? `EBIO_RESP_OKAY : `EBIO_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
		end else if (clk_en_in) begin
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata_in[7:0];
				w_strb_q <= s_axi_wstrb_in[0];
			end
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rs_q <= ebio_pkg::rs_idle;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `EBIO_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en_in) begin
			rs_q <= rs_d;
			arready_q <= rs_d == ebio_pkg::rs_idle;
			rvalid_q <= rs_d == ebio_pkg::rs_data;
			if (ar_take) begin
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_hit ? `EBIO_RESP_OKAY : `EBIO_RESP_SLVERR;
			end
		end
	end

	// Direction registers hold only what software wrote
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ph_dir_q <= `EBIO_DIR_RST;
			pj_dir_q <= `EBIO_DIR_RST;
			ph_lat_q <= `EBIO_LAT_RST;
			pj_lat_q <= `EBIO_LAT_RST;
		end else if (clk_en_in) begin
			if (ld_ph_dir) begin
				ph_dir_q <= wr_data;
			end
			if (ld_pj_dir) begin
				pj_dir_q <= wr_data;
			end
			if (ld_ph_lat) begin
				ph_lat_q <= wr_data;
			end
			if (ld_pj_lat) begin
				pj_lat_q <= wr_data;
			end
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ebc_q <= `EBIO_EBC_RST;
			ana_q <= `EBIO_ANA_RST;
			remap_q <= `EBIO_OPT_RST;
			ttl_q <= 1'b1;
		end else if (clk_en_in) begin
			if (ld_ebc) begin
				ebc_q <= wr_data & `EBIO_EBC_WMASK;
			end
			if (ld_ana) begin
				ana_q <= wr_data[3:0];
			end
			if (ld_opt) begin
				remap_q <= wr_data[`EBIO_OPT_REMAP];
			end
			ttl_q <= ttl_d;
		end
	end

	ebio_port u_port_h (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.dir_in(ph_dir_q),
		.lat_in(ph_lat_q),
		.drv_en_in(ph_drv_en),
		.drv_val_in(ph_drv_val),
		.hiz_in(ph_hiz),
		.pin_out(ph_pin_out),
		.pin_oe_out(ph_pin_oe_out)
	);

	ebio_port u_port_j (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.dir_in(pj_dir_q),
		.lat_in(pj_lat_q),
		.drv_en_in(pj_drv_en),
		.drv_val_in(pj_drv_val),
		.hiz_in(pj_hiz),
		.pin_out(pj_pin_out),
		.pin_oe_out(pj_pin_oe_out)
	);

	ebio_pin_sample u_samp_h (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.pin_in(ph_pin_in),
		.dig_in(~ph_ana_vec),
		.pins_out(ph_pins)
	);

	ebio_pin_sample u_samp_j (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.clk_en_in(clk_en_in),
		.pin_in(pj_pin_in),
		.dig_in(8'hff),
		.pins_out(pj_pins)
	);

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = rdata_q;
	assign ph_lo_ttl_out = ttl_q;
	assign analog_sel_out = ana_q;
	assign ext_bus_en_out = ~ebc_q[`EBIO_EBC_DIS];
	assign bus_write_style_out = ebc_q[`EBIO_EBC_WM_HI:`EBIO_EBC_WM_LO];
	assign bus_wait_out = ebc_q[`EBIO_EBC_WAIT_HI:`EBIO_EBC_WAIT_LO];
	assign pwm_pin_remap_out = remap_q;

endmodule

// File: inc/ebio_map.svh
// Register map, reset values and field positions of the shared I/O ports.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus, one word each.
`ifndef EBIO_MAP_SVH
`define EBIO_MAP_SVH

`define EBIO_OFS_PH_PINS 8'h00
`define EBIO_OFS_PH_LAT 8'h04
`define EBIO_OFS_PH_DIR 8'h08
`define EBIO_OFS_PJ_PINS 8'h0c
`define EBIO_OFS_PJ_LAT 8'h10
`define EBIO_OFS_PJ_DIR 8'h14
`define EBIO_OFS_EBC 8'h18
`define EBIO_OFS_ANA 8'h1c
`define EBIO_OFS_OPT 8'h20
`define EBIO_ADDR_WORD 8'hfc

`define EBIO_DIR_RST 8'hff
`define EBIO_LAT_RST 8'h00
`define EBIO_EBC_RST 8'h00
`define EBIO_EBC_WMASK 8'hb3
`define EBIO_EBC_DIS 7
`define EBIO_EBC_WAIT_HI 5
`define EBIO_EBC_WAIT_LO 4
`define EBIO_EBC_WM_HI 1
`define EBIO_EBC_WM_LO 0
`define EBIO_ANA_RST 4'hf
`define EBIO_OPT_RST 1'b0
`define EBIO_OPT_REMAP 0

`define EBIO_PJ_BUS_PINS 8'hdf
`define EBIO_PH_BUS_PINS 8'h0f

`define EBIO_RESP_OKAY 2'b00
`define EBIO_RESP_SLVERR 2'b10

`endif

// File: inc/ebio_pkg.sv
// Types shared by the shared I/O port design.
// Assumes nothing of its surroundings.
package ebio_pkg;

	typedef enum logic [3:0] {
		ws_idle = 4'h1,
		ws_got_a = 4'h2,
		ws_got_w = 4'h4,
		ws_resp = 4'h8
	} ebio_wst_t;

	typedef enum logic [1:0] {
		rs_idle = 2'h1,
		rs_data = 2'h2
	} ebio_rst_t;

endpackage

// File: test/ebio_mem_model.sv
// Far side of one port: memory devices and other drivers on the pins.
// Assumes the bench says which pins it drives and with what value.
module ebio_mem_model (
	input wire logic clock_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_val_in,
	output logic [7:0] wire_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_q = 8'h00;
	// Undriven pins toggle each cycle so a stale level never passes as data
	always @(posedge clock_in) float_q <= ~float_q;
	assign wire_out = (oe_in & pin_in) | (~oe_in & ext_en_in & ext_val_in)
		| (~oe_in & ~ext_en_in & float_q);
endmodule

// File: test/ebio_top_sva.sv
// Checker of the shared I/O ports, watching the top-level ports only.
// Assumes one clock domain, clock_in, with the active-low reset nrst_in.
module ebio_top_chk (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [3:0] mem_addr_hi_in,
	input wire logic mem_addr_latch_in,
	input wire logic mem_out_enable_in,
	input wire logic write_low_strobe_in,
	input wire logic write_high_strobe_in,
	input wire logic byte_address_bit_in,
	input wire logic lower_byte_select_in,
	input wire logic upper_byte_select_in,
	input wire logic [3:0] pwm_h_en_in,
	input wire logic [3:0] pwm_h_val_in,
	input wire logic [7:0] pj_ovr_out_en_in,
	input wire logic [7:0] pj_ovr_out_val_in,
	input wire logic [7:0] pj_ovr_in_en_in,
	input wire logic [7:0] ph_pin_out,
	input wire logic [7:0] ph_pin_oe_out,
	input wire logic [7:0] pj_pin_out,
	input wire logic [7:0] pj_pin_oe_out,
	input wire logic [3:0] analog_sel_out,
	input wire logic ext_bus_en_out,
	input wire logic pwm_pin_remap_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);
	wire logic [6:0] strb = {upper_byte_select_in, lower_byte_select_in, byte_address_bit_in,
		write_high_strobe_in, write_low_strobe_in, mem_out_enable_in, mem_addr_latch_in};
	// Pin 5 stays a port pin in bus mode, so overrides still reach it
	wire logic [7:0] own = ext_bus_en_out ? 8'h20 : 8'hff;
	wire logic [7:0] fo = pj_ovr_out_en_in & own;
	wire logic [7:0] fi = pj_ovr_in_en_in & ~pj_ovr_out_en_in & own;
	property p_bus_strobes;
		ext_bus_en_out && clk_en_in |=> {pj_pin_out[7:6], pj_pin_out[4:0]} == $past(strb)
			&& {pj_pin_oe_out[7:6], pj_pin_oe_out[4:0]} == 7'h7f;
	endproperty
	a_bus_strobes: assert property (p_bus_strobes)
		else $error("control strobes not on port J");
	property p_bus_addr;
		ext_bus_en_out && clk_en_in |=> ph_pin_out[3:0] == $past(mem_addr_hi_in)
			&& ph_pin_oe_out[3:0] == 4'hf;
	endproperty
	a_bus_addr: assert property (p_bus_addr)
		else $error("upper address not on port H");
	property p_reset_pins;
		$rose(nrst_in) |-> pj_pin_oe_out == 8'h00 && ph_pin_oe_out == 8'h00
			&& analog_sel_out == 4'hf && ext_bus_en_out;
	endproperty
	a_reset_pins: assert property (p_reset_pins)
		else $error("pins not inputs after reset");
	property p_force_out;
		clk_en_in |=> (pj_pin_oe_out & $past(fo)) == $past(fo)
			&& ((pj_pin_out ^ $past(pj_ovr_out_val_in)) & $past(fo)) == 8'h00;
	endproperty
	a_force_out: assert property (p_force_out)
		else $error("forced output not driven");
	property p_force_in;
		clk_en_in |=> (pj_pin_oe_out & $past(fi)) == 8'h00;
	endproperty
	a_force_in: assert property (p_force_in)
		else $error("forced input still driven");
	property p_pwm;
		!pwm_pin_remap_out && clk_en_in |=> (ph_pin_oe_out[7:4] & $past(pwm_h_en_in))
			== $past(pwm_h_en_in) && ((ph_pin_out[7:4] ^ $past(pwm_h_val_in))
			& $past(pwm_h_en_in)) == 4'h0;
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("pwm not on port H");
	property p_remap;
		pwm_pin_remap_out && analog_sel_out == 4'hf && clk_en_in |=> ph_pin_oe_out[7:4] == 4'h0;
	endproperty
	a_remap: assert property (p_remap)
		else $error("remapped pwm still drives");
	property p_read;
		s_axi_arvalid_in && s_axi_arready_out && clk_en_in |=> s_axi_rvalid_out;
	endproperty
	a_read: assert property (p_read)
		else $error("read answer late");
endmodule

bind ebio_top ebio_top_chk u_ebio_top_chk (.*);

// File: test/tb.sv
// Self-checking bench of the shared I/O ports over AXI4-Lite.
// Assumes the checker is bound to ebio_top and one far-side model per port.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, nrst_in, clk_en_in, psp_mode_in;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, lat, h_ext_en, h_ext_val, j_ext_en, j_ext_val;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, r;
	logic [3:0] s_axi_wstrb_in, mem_addr_hi_in, pwm_h_en_in, pwm_h_val_in, analog_sel_out;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic s_axi_rvalid_out, s_axi_rready_in, ph_lo_ttl_out, ext_bus_en_out, pwm_pin_remap_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, bus_write_style_out, bus_wait_out;
	logic mem_addr_latch_in, mem_out_enable_in, write_low_strobe_in, write_high_strobe_in;
	logic byte_address_bit_in, lower_byte_select_in, upper_byte_select_in;
	logic [7:0] ph_ovr_out_en_in, ph_ovr_out_val_in, ph_ovr_in_en_in;
	logic [7:0] pj_ovr_out_en_in, pj_ovr_out_val_in, pj_ovr_in_en_in;
	logic [7:0] ph_pin_in, ph_pin_out, ph_pin_oe_out, pj_pin_in, pj_pin_out, pj_pin_oe_out;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [17:0] t0 [9] = '{{8'h08, 8'hff, 2'b00}, {8'h14, 8'hff, 2'b00}, {8'h18, 8'h00, 2'b00},
		{8'h1c, 8'h0f, 2'b00}, {8'h20, 8'h00, 2'b00}, {8'h04, 8'h00, 2'b00},
		{8'h10, 8'h00, 2'b00}, {8'h00, 8'h09, 2'b00}, {8'h24, 8'h00, 2'b10}};
	integer fails = 0, checked = 0, seed = 32'haa41;
	ebio_top u_ebio_top (.*);
	ebio_mem_model u_ebio_mem_model_h (.clock_in, .pin_in(ph_pin_out), .oe_in(ph_pin_oe_out),
		.ext_en_in(h_ext_en), .ext_val_in(h_ext_val), .wire_out(ph_pin_in));
	ebio_mem_model u_ebio_mem_model_j (.clock_in, .pin_in(pj_pin_out), .oe_in(pj_pin_oe_out),
		.ext_en_in(j_ext_en), .ext_val_in(j_ext_val), .wire_out(pj_pin_in));
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checked = checked + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		bq.push_back(e);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h0, d};
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
		fork
			begin
				do @(posedge clock_in); while (s_axi_awready_out !== 1'b1);
				s_axi_awvalid_in <= 1'b0;
			end
			begin
				do @(posedge clock_in); while (s_axi_wready_out !== 1'b1);
				s_axi_wvalid_in <= 1'b0;
			end
		join
		do @(posedge clock_in); while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		// One idle edge so a following call never re-raises a strobe in the same step
		@(posedge clock_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		rq.push_back({e, 24'h0, d});
		s_axi_araddr_in <= a;
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
		do @(posedge clock_in); while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		do @(posedge clock_in); while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		@(posedge clock_in);
	endtask
	// Answers are compared when they appear, against the oldest note
	always @(posedge clock_in) begin
		if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in)
			chk({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
		if (s_axi_bvalid_out === 1'b1 && s_axi_bready_in)
			chk(s_axi_bresp_out, bq.pop_front());
	end
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	initial begin
		#50us;
		fails = fails + 1;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end
	initial begin
		{nrst_in, psp_mode_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
		{s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		{mem_addr_latch_in, mem_out_enable_in, write_low_strobe_in, write_high_strobe_in} = '0;
		{byte_address_bit_in, lower_byte_select_in, upper_byte_select_in, pwm_h_en_in} = '0;
		{ph_ovr_out_en_in, ph_ovr_out_val_in, ph_ovr_in_en_in, pwm_h_val_in, j_ext_val} = '0;
		{pj_ovr_out_en_in, pj_ovr_out_val_in, pj_ovr_in_en_in, j_ext_en} = '0;
		{h_ext_en, h_ext_val, mem_addr_hi_in, s_axi_wstrb_in, clk_en_in} = {8'hf0, 8'hff, 4'h9, 4'hf, 1'b1};
		repeat (6) @(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		chk({pj_pin_oe_out, ph_pin_oe_out}, 16'hdf0f);
		foreach (t0[i]) rd(t0[i][17:10], t0[i][9:2], t0[i][1:0]);
		wr(8'h24, 8'h55, 2'b10);
		repeat (40) begin
			@(posedge clock_in);
			r = $random(seed);
			{upper_byte_select_in, lower_byte_select_in, byte_address_bit_in, write_high_strobe_in,
				write_low_strobe_in, mem_out_enable_in, mem_addr_latch_in} <= r[6:0];
			{mem_addr_hi_in, pwm_h_en_in, pwm_h_val_in} <= r[11:0];
			{pj_ovr_in_en_in, pj_ovr_out_val_in, pj_ovr_out_en_in} <= r[31:8];
			{ph_ovr_in_en_in, ph_ovr_out_val_in, ph_ovr_out_en_in} <= r[27:4];
		end
		repeat (2) @(posedge clock_in);
		chk(ph_pin_out[3:0], mem_addr_hi_in);
		{pj_ovr_in_en_in, pj_ovr_out_en_in, ph_ovr_out_en_in, ph_ovr_in_en_in} <= '0;
		pwm_h_en_in <= 4'h0;
		r = $random(seed);
		lat = r[7:0];
		wr(8'h18, 8'h80, 2'b00);
		wr(8'h10, lat, 2'b00);
		wr(8'h14, 8'hf0, 2'b00);
		{j_ext_en, j_ext_val} <= {8'hf0, ~lat};
		repeat (2) @(posedge clock_in);
		chk({pj_pin_oe_out, pj_pin_out & 8'h0f}, {8'h0f, lat & 8'h0f});
		rd(8'h10, lat, 2'b00);
		rd(8'h0c, {~lat[7:4], lat[3:0]}, 2'b00);
		{pj_ovr_out_en_in, pj_ovr_in_en_in, pj_ovr_out_val_in} <= {8'h30, 8'h03, 8'h20};
		rd(8'h14, 8'hf0, 2'b00);
		chk(pj_pin_oe_out, 8'h3c);
		{pj_ovr_out_en_in, pj_ovr_in_en_in} <= 16'h0;
		s_axi_wstrb_in <= 4'h0;
		wr(8'h10, ~lat, 2'b00);
		s_axi_wstrb_in <= 4'hf;
		rd(8'h10, lat, 2'b00);
		wr(8'h0c, ~lat, 2'b00);
		rd(8'h10, ~lat, 2'b00);
		wr(8'h1c, 8'h00, 2'b00);
		wr(8'h04, lat, 2'b00);
		wr(8'h08, 8'h00, 2'b00);
		repeat (2) @(posedge clock_in);
		chk({ph_pin_oe_out, ph_pin_out, ph_lo_ttl_out}, {8'hff, lat, 1'b0});
		psp_mode_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk(ph_lo_ttl_out, 1'b1);
		{psp_mode_in, pwm_h_en_in, pwm_h_val_in} <= {1'b0, 4'ha, ~lat[7:4]};
		repeat (2) @(posedge clock_in);
		chk(ph_pin_out[7:4], {~lat[7], lat[6], ~lat[5], lat[4]});
		wr(8'h20, 8'h01, 2'b00);
		repeat (2) @(posedge clock_in);
		chk({pwm_pin_remap_out, ph_pin_out[7:4]}, {1'b1, lat[7:4]});
		wr(8'h1c, 8'h0f, 2'b00);
		rd(8'h00, {4'h0, lat[3:0]}, 2'b00);
		pwm_h_en_in <= 4'h0;
		wr(8'h18, 8'hff, 2'b00);
		rd(8'h18, 8'hb3, 2'b00);
		chk({bus_write_style_out, bus_wait_out}, 4'hf);
		wr(8'h18, 8'h00, 2'b00);
		wr(8'h14, 8'h00, 2'b00);
		repeat (2) @(posedge clock_in);
		chk({pj_pin_oe_out, pj_pin_out[5], ph_lo_ttl_out}, {8'hff, ~lat[5], 1'b1});
		// Clock enable low must freeze the pin drivers
		clk_en_in <= 1'b0;
		pj_ovr_in_en_in <= 8'hff;
		repeat (3) @(posedge clock_in);
		chk(pj_pin_oe_out, 8'hff);
		clk_en_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		chk(pj_pin_oe_out, 8'hdf);
		pj_ovr_in_en_in <= 8'h00;
		close_out();
	end
endmodule
